// >>> rtl/bt_timer.sv
// The strobed register port is this design's own decision.
`timescale 1ns/1ps


module bt_timer
(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  output logic            irq_o,
  output logic      [7:0] irq_vector_o,
  output logic            wake_o,
  output logic            overflow_o
);

  // ****************************************
  // state
  // ****************************************
  logic [7:0]            mode_q;
  logic [7:0]            count_q;
  logic [7:0]            count_d;
  logic [bt_pkg::EV_W-1:0] stat_q;
  logic [bt_pkg::EV_W-1:0] stat_d;
  logic [bt_pkg::EV_W-1:0] en_q;
  logic                  lp_q;
  logic [7:0]            rdata_q;
  logic                  tick;
  logic                  run;
  logic                  wrap;
  logic [bt_pkg::EV_W-1:0] ev;

  // address match used by several decoders
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  assign run = mode_q[bt_pkg::RUN_BIT];

  // ****************************************
  // prescaler
  // ****************************************
  // divisor chosen by select
  bt_prescaler u_pre
  (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .run_i     (run),
    .sel_i     (mode_q[bt_pkg::PRE_MSB:bt_pkg::PRE_LSB]),
    .tick_o    (tick)
  );

  assign wrap = tick && (count_q == bt_pkg::COUNT_MAX);

  // ****************************************
  // mode register
  // ****************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      mode_q <= bt_pkg::MODE_RST;
    end
    else if (wr_i && hit(addr_i, bt_pkg::MODE_ADDR))
    begin
      mode_q <= wdata_i & bt_pkg::MODE_MASK;
    end
  end

  // ****************************************
  // counter
  // ****************************************
  // a software write wins over a tick in the same cycle
  // interval runs from preload up to the wrap
  always_comb
  begin
    count_d = count_q;
    if (wr_i && hit(addr_i, bt_pkg::COUNT_ADDR))
    begin
      count_d = wdata_i;
    end
    else if (tick)
    begin
      count_d = count_q + bt_pkg::COUNT_ONE;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      count_q <= bt_pkg::COUNT_RST;
    end
    else
    begin
      count_q <= count_d;
    end
  end

  // ****************************************
  // low-power mode control
  // ****************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      lp_q <= 1'b0;
    end
    else if (wr_i && hit(addr_i, bt_pkg::LP_ADDR))
    begin
      lp_q <= wdata_i[bt_pkg::LP_BIT];
    end
  end

  // ****************************************
  // events and interrupt
  // ****************************************
  always_comb
  begin
    ev = '0;
    ev[bt_pkg::EV_OVF]  = wrap;
    ev[bt_pkg::EV_WAKE] = wrap && lp_q;
  end

  // clear only by software; set beats clear
  always_comb
  begin
    stat_d = stat_q;
    if (wr_i && hit(addr_i, bt_pkg::IRQ_CLR_ADDR))
    begin
      stat_d = stat_q & ~wdata_i[bt_pkg::EV_W-1:0];
    end
    stat_d = stat_d | ev;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      stat_q <= '0;
    end
    else
    begin
      stat_q <= stat_d;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      en_q <= '0;
    end
    else if (wr_i && hit(addr_i, bt_pkg::IRQ_EN_ADDR))
    begin
      en_q <= wdata_i[bt_pkg::EV_W-1:0];
    end
  end

  // level request while enabled flag set
  assign irq_o        = |(stat_q & en_q);
  assign irq_vector_o = bt_pkg::OVF_VECTOR;
  assign wake_o       = stat_q[bt_pkg::EV_WAKE];
  assign overflow_o   = stat_q[bt_pkg::EV_OVF];

  // ****************************************
  // read port
  // ****************************************
  // data valid the cycle after the strobe only
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      rdata_q <= '0;
    end
    else if (!rd_i)
    begin
      rdata_q <= '0;
    end
    else if (hit(addr_i, bt_pkg::MODE_ADDR))
    begin
      rdata_q <= mode_q;
    end
    else if (hit(addr_i, bt_pkg::COUNT_ADDR))
    begin
      rdata_q <= count_q;
    end
    else if (hit(addr_i, bt_pkg::IRQ_STAT_ADDR))
    begin
      rdata_q <= {6'h00, stat_q};
    end
    else if (hit(addr_i, bt_pkg::IRQ_EN_ADDR))
    begin
      rdata_q <= {6'h00, en_q};
    end
    else if (hit(addr_i, bt_pkg::LP_ADDR))
    begin
      rdata_q <= {7'h00, lp_q};
    end
    else
    begin
      rdata_q <= '0; // unmapped and clear register read zero
    end
  end

  assign rdata_o = rdata_q;

  // ****************************************
  // checks
  // ****************************************
  a_stop_holds: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (!run && !(wr_i && addr_i == bt_pkg::COUNT_ADDR))
      |=> $stable(count_q))
    else $error("count moved while stopped");

  a_tick_adv: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (tick && !(wr_i && addr_i == bt_pkg::COUNT_ADDR))
      |=> count_q == $past(count_q) + 8'h01)
    else $error("count did not advance on tick");

  a_wrap_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wrap |=> overflow_o && count_q == 8'h00)
    else $error("wrap did not set flag");

  a_flag_sticky: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (overflow_o && !(wr_i && addr_i == bt_pkg::IRQ_CLR_ADDR))
      |=> overflow_o)
    else $error("flag dropped without clear");

  a_no_reload: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(overflow_o) |-> count_q == 8'h00)
    else $error("counter reloaded on wrap");

  a_irq_level: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (overflow_o && en_q[bt_pkg::EV_OVF]) |-> irq_o
      && irq_vector_o == 8'h08)
    else $error("enabled overflow without request");

  a_wake_lp: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (wrap && lp_q) |=> wake_o && overflow_o)
    else $error("no wake on low-power overflow");

  a_div_two: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (tick && run && mode_q[6:4] == 3'b111 && $stable(mode_q)
      && !(wr_i && addr_i == bt_pkg::MODE_ADDR))
      |=> !tick ##1 tick)
    else $error("divide by two spacing wrong");

  a_stop_pre: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !run |-> !tick)
    else $error("tick while stopped");

endmodule

// >>> rtl/bt_pkg.sv
package bt_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] MODE_ADDR     = 8'hd8; // basic_timer_mode
  localparam logic [7:0] COUNT_ADDR    = 8'hd9; // basic_timer_count
  localparam logic [7:0] IRQ_STAT_ADDR = 8'hda; // sticky event status
  localparam logic [7:0] IRQ_EN_ADDR   = 8'hdb; // event enables
  localparam logic [7:0] IRQ_CLR_ADDR  = 8'hdc; // write one to clear
  localparam logic [7:0] LP_ADDR       = 8'hdd; // low-power mode control

  localparam logic [7:0] MODE_RST  = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_ONE = 8'h01;

  // ****************************************
  // field layout
  // ****************************************
  localparam int RUN_BIT     = 7;
  localparam int PRE_MSB     = 6;
  localparam int PRE_LSB     = 4;
  localparam logic [7:0] MODE_MASK = 8'hf0; // bits 3:0 read zero

  // status / enable / clear layout
  localparam int EV_OVF  = 0;
  localparam int EV_WAKE = 1;
  localparam int EV_W    = 2;

  // low-power control bit
  localparam int LP_BIT = 0;

  // interrupt vector of the overflow request
  localparam logic [7:0] OVF_VECTOR = 8'h08;

  // prescaler
  localparam int PRE_W = 8;
  localparam logic [PRE_W-1:0] PRE_ONE = 8'h01;

endpackage

// >>> rtl/bt_prescaler.sv
`timescale 1ns/1ps

// divider of the instruction clock, held while stopped; tick once per divided period
module bt_prescaler
(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic       run_i,
  input  wire logic [2:0] sel_i,
  output logic            tick_o
);

  logic [bt_pkg::PRE_W-1:0] div_q;
  logic [bt_pkg::PRE_W-1:0] div_d;
  logic [bt_pkg::PRE_W-1:0] mask;

  // code 000 divides by 256, each step up halves the divisor
  always_comb
  begin
    mask   = 8'hff >> sel_i;
    div_d  = div_q + bt_pkg::PRE_ONE;
    tick_o = run_i && ((div_q & mask) == mask);
  end

  // counter frozen while stopped so the phase resumes intact
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      div_q <= '0;
    end
    else if (run_i)
    begin
      div_q <= div_d;
    end
  end

endmodule

// >>> verif/bt_core_model.sv
`timescale 1ns/1ps

// ****************************************
// core side of the interrupt request
// ****************************************
module bt_core_model
(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic       irq_i,
  input  wire logic [7:0] vector_i,
  output logic      [7:0] pc_o,
  output int              taken_o
);
  logic irq_q;

  // jump to vector on rising request
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      irq_q   <= 1'b0;
      pc_o    <= 8'h00;
      taken_o <= 0;
    end
    else
    begin
      irq_q <= irq_i;
      if (irq_i && !irq_q)
      begin
        pc_o    <= vector_i;
        taken_o <= taken_o + 1; // level request counts once
      end
    end
  end
endmodule

// >>> verif/bt_timer_tb_top.sv
`timescale 1ns/1ps

// ****************************************
// register level bench
// ****************************************
module bt_timer_tb_top;
  logic       clk_sys_i = 1'b0;
  logic       rst_i     = 1'b1;
  logic [7:0] addr_i    = 8'h00;
  logic [7:0] wdata_i   = 8'h00;
  logic       wr_i      = 1'b0;
  logic       rd_i      = 1'b0;
  logic [7:0] rdata_o;
  logic       irq_o;
  logic [7:0] irq_vector_o;
  logic       wake_o;
  logic       overflow_o;
  logic [7:0] pc;
  int         taken;
  int         bad_count;
  int         total_checks;
  int         n;

  always #5 clk_sys_i = ~clk_sys_i;

  bt_timer i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .irq_o(irq_o), .irq_vector_o(irq_vector_o), .wake_o(wake_o),
    .overflow_o(overflow_o));

  bt_core_model i_core (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .irq_i(irq_o), .vector_i(irq_vector_o), .pc_o(pc), .taken_o(taken));

  // mismatch is counted, never fatal, so one run shows every fault
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    wr_i    <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    rd_i   <= 1'b0;
    @(negedge clk_sys_i);
    chk(rdata_o, e);
  endtask

  task automatic do_rst;
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
  endtask

  // bounded wait; a hang ends the run
  task automatic wait_ovf;
    n = 0;
    while (overflow_o !== 1'b1 && n < 2000)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    if (n >= 2000)
    begin
      chk(8'h00, 8'h01);
      conclude();
    end
  endtask

  initial
  begin
    do_rst();
    rd(bt_pkg::MODE_ADDR, bt_pkg::MODE_RST);
    rd(bt_pkg::COUNT_ADDR, bt_pkg::COUNT_RST);
    rd(8'h00, 8'h00);
    wr(bt_pkg::MODE_ADDR, 8'h7f);
    rd(bt_pkg::MODE_ADDR, 8'h70);
    wr(bt_pkg::COUNT_ADDR, 8'h5a);
    repeat (20) @(posedge clk_sys_i);
    rd(bt_pkg::COUNT_ADDR, 8'h5a);
    // preload 0xfe gives two ticks of each divisor
    for (int s = 0; s < 8; s++)
    begin
      do_rst();
      wr(bt_pkg::COUNT_ADDR, 8'hfe);
      wr(bt_pkg::MODE_ADDR, {1'b0, s[2:0], 4'h0});
      wr(bt_pkg::MODE_ADDR, {1'b1, s[2:0], 4'h0});
      wait_ovf();
      chk({7'h00, n >= 2*(256>>s)-2 && n <= 2*(256>>s)+3}, 8'h01);
    end
    wr(bt_pkg::MODE_ADDR, 8'h00);
    // one more divide-by-two tick lands before the stop takes hold
    rd(bt_pkg::COUNT_ADDR, 8'h01);
    repeat (600) @(posedge clk_sys_i);
    chk({7'h00, overflow_o}, 8'h01);
    chk({7'h00, irq_o}, 8'h00);
    wr(bt_pkg::IRQ_EN_ADDR, 8'h01);
    @(negedge clk_sys_i);
    chk({7'h00, irq_o}, 8'h01);
    @(negedge clk_sys_i);
    chk(pc, bt_pkg::OVF_VECTOR);
    wr(bt_pkg::IRQ_CLR_ADDR, 8'h01);
    @(negedge clk_sys_i);
    chk({6'h00, irq_o, overflow_o}, 8'h00);
    rd(bt_pkg::IRQ_STAT_ADDR, 8'h00);
    chk(taken[7:0], 8'h01);
    // wake-up with low-power mode set
    do_rst();
    wr(bt_pkg::LP_ADDR, 8'h01);
    wr(bt_pkg::COUNT_ADDR, 8'hff);
    wr(bt_pkg::MODE_ADDR, 8'hf0);
    wait_ovf();
    repeat (2) @(posedge clk_sys_i);
    chk({7'h00, wake_o}, 8'h01);
    rd(bt_pkg::IRQ_STAT_ADDR, 8'h03);
    wr(bt_pkg::IRQ_CLR_ADDR, 8'h03);
    rd(bt_pkg::IRQ_STAT_ADDR, 8'h00);
    // software reload after the wrap gives a short second interval
    wr(bt_pkg::COUNT_ADDR, 8'hfe);
    wait_ovf();
    chk({7'h00, overflow_o}, 8'h01);
    conclude();
  end
endmodule
